// [verilog/sdcmd_dev.sv]
// Behaviour
// - chip select high executes nothing new
// - selected all-high is a no-op
// - strobe levels decode into seven commands
// - mode load picks base or extended register
// - controller loads modes only when idle
// - activate opens row until bank precharged
// - bank, column and auto precharge bit
// - auto precharge after burst and row time
// - controller waits precharge period after it
// - masked write bytes are discarded
// - scope bit selects one or all banks
// - precharge of closed bank is no-op
// - refresh with clock enable low self-refreshes
// - controller refreshes every 3.9us on average
// - self refresh stops loop and termination
// - self refresh ignores all but clock enable
// - controller waits exit time before reads
// - reads switch data termination off briefly
// - snooping only in dual load setting
// - other pins always keep termination
// - reset edge samples clock enable rank
// - data termination set by extended register
// - clock enable high except self refresh; strap level while reset pin low
//
// Local design decisions: the register offsets and strobed register access.
`timescale 1ns/100ps
`default_nettype none
module sdcmd_dev #(
   parameter int READ_LAT  = 10,
   parameter int BURST_LEN = 4,
   parameter int WRITE_LAT = 4,
   parameter int RAS_MIN   = 16,
   parameter int PRE_CYC   = 8
) (
   input  wire logic                          clk_sys_i,        // clock
   input  wire logic                          reset_n_i,        // reset
   sdcmd_if.dev                               pins,             // pins
   output sdcmd_pkg::sdcmd_cmd_t              cmd_o,            // command
   output logic [sdcmd_pkg::BANK_W-1:0]       cmd_bank_o,       // bank
   output logic [sdcmd_pkg::ADDR_W-1:0]       cmd_addr_o,       // row/col
   output logic                               auto_pre_o,       // ap req
   output logic [sdcmd_pkg::NBANK-1:0]        bank_open_o,      // open
   output logic [sdcmd_pkg::NBANK-1:0]        bank_pre_o,       // closing
   output logic [sdcmd_pkg::ADDR_W-1:0]       refresh_row_o,    // ref row
   output logic                               self_refresh_o,   // in sr
   output logic                               dll_en_o,         // dll on
   output logic                               dll_reset_o,      // dll rst
   output logic                               term_ca_o,        // c/a odt
   output logic                               term_ca_half_o,   // half cal
   output logic                               dual_rank_o,      // 2 ranks
   output logic                               term_data_o,      // data odt
   output logic [1:0]                         term_data_sel_o,  // odt val
   output logic [sdcmd_pkg::ADDR_W-1:0]       mode_reg_o,       // mode reg
   output logic [sdcmd_pkg::ADDR_W-1:0]       ext_mode_reg_o,   // ext mode
   output logic                               wr_valid_o,       // wr beat
   output logic [sdcmd_pkg::DQ_W-1:0]         wr_data_o,        // wr data
   output logic [sdcmd_pkg::MASK_W-1:0]       wr_byte_en_o      // byte en
);
   localparam int CW        = 8;
   localparam int BURST_CYC = BURST_LEN / 2;
   localparam int ODT_OFF   = BURST_LEN / 2 + 2;
   // tap after the sampling edge so data termination drops read_latency-1 on
   localparam int SNP_W     = READ_LAT - 1;

   logic [2:0]            rcw;
   logic                  sel, live, ap_req, sr_exit, rd_snoop;
   logic                  do_act, do_rd, do_wr, do_pre, do_aref, do_sref;
   logic                  do_mrs, snp_tap, wr_tap, wr_act, rst_rise;
   logic                  sr_tick, odt_dual, rst_prev, in_sr;
   logic [SNP_W-1:0]      snp_pipe;
   logic [WRITE_LAT-1:0]  wr_pipe;
   logic [CW-1:0]         odt_cnt, beat_cnt;
   logic [15:0]           sr_cnt;
   sdcmd_pkg::sdcmd_cmd_t next_cmd;

   assign rcw = {pins.ras_n, pins.cas_n, pins.we_n};
   assign sel = ~pins.cs_n;
   assign live = sel & ~in_sr;
   assign do_act  = live & pins.cke & (rcw == sdcmd_pkg::PIN_ACT);
   assign do_rd   = live & pins.cke & (rcw == sdcmd_pkg::PIN_RD);
   assign do_wr   = live & pins.cke & (rcw == sdcmd_pkg::PIN_WR);
   assign do_pre  = live & pins.cke & (rcw == sdcmd_pkg::PIN_PRE);
   assign do_mrs  = live & pins.cke & (rcw == sdcmd_pkg::PIN_MRS);
   assign do_aref = live & pins.cke & (rcw == sdcmd_pkg::PIN_REF);
   assign do_sref = live & ~pins.cke & (rcw == sdcmd_pkg::PIN_REF);
   assign ap_req  = pins.addr[sdcmd_pkg::AP_BIT];
   assign sr_exit = in_sr & pins.cke;
   assign rd_snoop = ~in_sr & (rcw == sdcmd_pkg::PIN_RD);
   assign snp_tap  = snp_pipe[SNP_W-1];
   assign wr_tap   = wr_pipe[WRITE_LAT-1];
   assign wr_act   = wr_tap | (beat_cnt > CW'(1));
   assign rst_rise = pins.rst_pin_n & ~rst_prev;
   assign sr_tick  = in_sr & (sr_cnt == 16'(sdcmd_pkg::REF_AVG_CYC - 1));
   // data termination value from extended register
   assign odt_dual = (ext_mode_reg_o[sdcmd_pkg::EMR_ODT_LSB +: 2]
                      == sdcmd_pkg::EMR_ODT_DUAL);

   assign next_cmd = do_act  ? sdcmd_pkg::CMD_ACT  :
                     do_rd   ? sdcmd_pkg::CMD_RD   :
                     do_wr   ? sdcmd_pkg::CMD_WR   :
                     do_pre  ? sdcmd_pkg::CMD_PRE  :
                     do_aref ? sdcmd_pkg::CMD_AREF :
                     do_sref ? sdcmd_pkg::CMD_SREF :
                     do_mrs  ? sdcmd_pkg::CMD_MRS  :
                     live    ? sdcmd_pkg::CMD_NOP  : sdcmd_pkg::CMD_DESEL;

   always_ff @(posedge clk_sys_i)
   begin
      if (!reset_n_i)
      begin
         cmd_o      <= sdcmd_pkg::CMD_DESEL;
         cmd_bank_o <= '0;
         cmd_addr_o <= '0;
         auto_pre_o <= 1'b0;
      end
      else
      begin
         cmd_o      <= next_cmd;
         cmd_bank_o <= pins.ba;
         cmd_addr_o <= pins.addr;
         auto_pre_o <= (do_rd | do_wr) & ap_req;
      end
   end

   generate
      for (genvar b = 0; b < sdcmd_pkg::NBANK; b++)
      begin : g_bank
         logic          hit, act_b, acc_b, ap_fire, pre_b, ap_pend;
         logic [CW-1:0] ras_cnt, pre_cnt, ap_cnt;

         assign hit     = (pins.ba == sdcmd_pkg::BANK_W'(b));
         assign act_b   = do_act & hit & ~bank_open_o[b] & ~bank_pre_o[b];
         assign acc_b   = (do_rd | do_wr) & hit & bank_open_o[b] & ap_req;
         // precharge after burst once row time met
         assign ap_fire = ap_pend & (ap_cnt == '0) & (ras_cnt == '0);
         // scope bit precharges all banks, closed bank ignored
         assign pre_b   = bank_open_o[b] & (ap_fire | (do_pre &
                          (pins.addr[sdcmd_pkg::AP_BIT] | hit)));

         always_ff @(posedge clk_sys_i)
         begin
            if (!reset_n_i)
            begin
               bank_open_o[b] <= 1'b0;
               bank_pre_o[b]  <= 1'b0;
               ap_pend        <= 1'b0;
               ras_cnt        <= '0;
               pre_cnt        <= '0;
               ap_cnt         <= '0;
            end
            else
            begin
               if (ras_cnt != '0)
                  ras_cnt <= ras_cnt - CW'(1);
               if (ap_cnt != '0)
                  ap_cnt <= ap_cnt - CW'(1);
               if (pre_cnt != '0)
                  pre_cnt <= pre_cnt - CW'(1);
               bank_pre_o[b] <= pre_b | (pre_cnt > CW'(1));
               if (act_b)
               begin
                  bank_open_o[b] <= 1'b1;
                  ras_cnt        <= CW'(RAS_MIN);
               end
               if (acc_b)
               begin
                  ap_pend <= 1'b1;
                  ap_cnt  <= do_wr ? CW'(WRITE_LAT + BURST_CYC)
                                   : CW'(BURST_CYC);
               end
               if (pre_b)
               begin
                  bank_open_o[b] <= 1'b0;
                  ap_pend        <= 1'b0;
                  pre_cnt        <= CW'(PRE_CYC);
               end
            end
         end
      end
   endgenerate

   // mode register load by bank code
   always_ff @(posedge clk_sys_i)
   begin
      if (!reset_n_i)
      begin
         mode_reg_o     <= '0;
         ext_mode_reg_o <= '0;
      end
      else if (do_mrs && pins.ba[1:0] == sdcmd_pkg::MR_BASE)
         mode_reg_o <= pins.addr;
      else if (do_mrs && pins.ba[1:0] == sdcmd_pkg::MR_EXT)
         ext_mode_reg_o <= pins.addr;
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (!reset_n_i)
      begin
         refresh_row_o <= '0;
         sr_cnt        <= '0;
      end
      else
      begin
         if (do_aref | do_sref | sr_tick)
            refresh_row_o <= refresh_row_o + sdcmd_pkg::ADDR_W'(1);
         sr_cnt <= (in_sr & ~sr_tick) ? sr_cnt + 16'(1) : 16'(0);
      end
   end

   // loop and termination follow self refresh
   always_ff @(posedge clk_sys_i)
   begin
      if (!reset_n_i)
      begin
         in_sr           <= 1'b0;
         self_refresh_o  <= 1'b0;
         dll_en_o        <= 1'b1;
         dll_reset_o     <= 1'b0;
         rst_prev        <= 1'b0;
         dual_rank_o     <= 1'b0;
         term_ca_half_o  <= 1'b1;
         term_ca_o       <= 1'b1;
         snp_pipe        <= '0;
         odt_cnt         <= '0;
         term_data_o     <= 1'b1;
         term_data_sel_o <= '0;
         wr_pipe         <= '0;
         beat_cnt        <= '0;
         wr_valid_o      <= 1'b0;
         wr_data_o       <= '0;
         wr_byte_en_o    <= '0;
      end
      else
      begin
         in_sr          <= (in_sr | do_sref) & ~sr_exit;
         self_refresh_o <= (in_sr | do_sref) & ~sr_exit;
         dll_en_o       <= ~((in_sr | do_sref) & ~sr_exit);
         dll_reset_o    <= sr_exit;
         rst_prev       <= pins.rst_pin_n;
         // command and address termination stays on
         term_ca_o <= 1'b1;
         // rank strap on rising reset pin
         if (rst_rise)
         begin
            dual_rank_o    <= pins.cke;
            term_ca_half_o <= ~pins.cke;
         end
         // snooped reads act only in dual load setting
         snp_pipe <= SNP_W'({snp_pipe, rd_snoop});
         if (snp_tap)
            odt_cnt <= CW'(ODT_OFF);
         else if (odt_cnt != '0)
            odt_cnt <= odt_cnt - CW'(1);
         term_data_o <= ~(in_sr | do_sref) &
                        ~(odt_dual & (snp_tap | (odt_cnt > CW'(1))));
         term_data_sel_o <= ext_mode_reg_o[sdcmd_pkg::EMR_ODT_LSB +: 2];
         // masked bytes get no write enable
         wr_pipe <= WRITE_LAT'({wr_pipe, do_wr});
         if (wr_tap)
            beat_cnt <= CW'(BURST_CYC);
         else if (beat_cnt != '0)
            beat_cnt <= beat_cnt - CW'(1);
         wr_valid_o   <= wr_act;
         wr_data_o    <= pins.dq;
         wr_byte_en_o <= wr_act ? ~pins.write_byte_mask : '0;
      end
   end
endmodule
`default_nettype wire

// [verilog/sdcmd_pkg.sv]
`default_nettype none
package sdcmd_pkg;
   localparam int BANK_W   = 3;
   localparam int ADDR_W   = 12;
   localparam int DQ_W     = 32;
   localparam int MASK_W   = 4;
   localparam int NBANK    = 8;
   // row/column strobe and write enable pin levels {ras_n, cas_n, we_n}
   localparam logic [2:0] PIN_NOP = 3'h7;
   localparam logic [2:0] PIN_ACT = 3'h3;
   localparam logic [2:0] PIN_RD  = 3'h5;
   localparam logic [2:0] PIN_WR  = 3'h4;
   localparam logic [2:0] PIN_PRE = 3'h2;
   localparam logic [2:0] PIN_REF = 3'h1;
   localparam logic [2:0] PIN_MRS = 3'h0;
   // position of precharge_scope_bit on the address bus
   localparam int AP_BIT = 8;
   localparam logic [1:0] MR_BASE = 2'h0;
   localparam logic [1:0] MR_EXT  = 2'h1;
   // data termination setting in the extended mode register
   localparam int EMR_ODT_LSB = 2;
   localparam logic [1:0] EMR_ODT_DUAL = 2'h1;
   // timing
   localparam int CLK_MHZ     = 50;
   localparam int REF_AVG_NS  = 3900;
   localparam int REF_MAX_NS  = 35100;
   localparam int REF_AVG_CYC = REF_AVG_NS * CLK_MHZ / 1000;
   localparam int REF_MAX_CYC = REF_MAX_NS * CLK_MHZ / 1000;
   localparam int EXIT_WAIT_CYC = 20000;
   // controller register offsets and fields
   localparam logic [3:0] REG_CMD   = 4'h0;
   localparam logic [3:0] REG_WDATA = 4'h4;
   localparam logic [3:0] REG_STAT  = 4'h8;
   localparam logic [3:0] REG_CTRL  = 4'hC;
   localparam int CMD_OP_LSB   = 0;
   localparam int CMD_BA_LSB   = 4;
   localparam int CMD_ADDR_LSB = 8;
   localparam int CTRL_RST_BIT   = 0;
   localparam int CTRL_STRAP_BIT = 1;
   localparam int CTRL_REFEN_BIT = 2;
   localparam int CTRL_MASK_LSB  = 4;
   localparam logic [7:0] CTRL_RESET = 8'h00;

   typedef enum logic [3:0] {
      CMD_DESEL, CMD_NOP, CMD_ACT, CMD_RD, CMD_WR,
      CMD_PRE, CMD_AREF, CMD_SREF, CMD_MRS, CMD_SREX
   } sdcmd_cmd_t;

   function automatic logic [2:0] sdcmd_pins(input sdcmd_cmd_t op);
      case (op)
         CMD_ACT:  return PIN_ACT;
         CMD_RD:   return PIN_RD;
         CMD_WR:   return PIN_WR;
         CMD_PRE:  return PIN_PRE;
         CMD_AREF: return PIN_REF;
         CMD_SREF: return PIN_REF;
         CMD_MRS:  return PIN_MRS;
         default:  return PIN_NOP;
      endcase
   endfunction
endpackage
`default_nettype wire

// [verilog/sdcmd_if.sv]
`timescale 1ns/100ps
`default_nettype none
interface sdcmd_if;
   logic                        rst_pin_n;
   logic                        cke;
   logic                        cs_n;
   logic                        ras_n;
   logic                        cas_n;
   logic                        we_n;
   logic [sdcmd_pkg::BANK_W-1:0] ba;
   logic [sdcmd_pkg::ADDR_W-1:0] addr;
   logic [sdcmd_pkg::DQ_W-1:0]   dq;
   logic [sdcmd_pkg::MASK_W-1:0] write_byte_mask;

   modport ctrl (output rst_pin_n, cke, cs_n, ras_n, cas_n, we_n,
                 output ba, addr, dq, write_byte_mask);
   modport dev  (input rst_pin_n, cke, cs_n, ras_n, cas_n, we_n,
                 input ba, addr, dq, write_byte_mask);
endinterface
`default_nettype wire

// [verilog/sdcmd_ctrl.sv]
`timescale 1ns/100ps
`default_nettype none
module sdcmd_ctrl #(
   parameter int MODE_WAIT = 4,
   parameter int AP_WAIT   = 16,
   parameter int REF_WAIT  = 16,
   parameter int EXIT_WAIT = sdcmd_pkg::EXIT_WAIT_CYC
) (
   input  wire logic        clk_sys_i,  // clock
   input  wire logic        reset_n_i,  // reset
   sdcmd_if.ctrl            pins,       // pins
   input  wire logic [3:0]  addr_i,     // reg address
   input  wire logic [31:0] wdata_i,    // write data
   input  wire logic        wr_i,       // write strobe
   input  wire logic        rd_i,       // read strobe
   output logic [31:0]      rdata_o     // read data
);
   localparam int BW = 16;

   sdcmd_pkg::sdcmd_cmd_t           op;
   logic [sdcmd_pkg::BANK_W-1:0]    op_ba;
   logic [sdcmd_pkg::ADDR_W-1:0]    op_addr;
   logic                            pend;
   logic [7:0]                      ctrl;
   logic [31:0]                     wdata;
   logic [BW-1:0]                   busy_cnt;
   logic [BW-1:0]                   ref_cnt;
   logic                            in_sr;
   logic                            can_go;
   logic                            ref_go;
   logic                            usr_go;
   logic                            next_sr;
   logic [BW-1:0]                   next_busy;
   logic                            wr_cmd;
   logic [31:0]                     rd_mux;

   assign can_go = (busy_cnt == '0) & ctrl[sdcmd_pkg::CTRL_RST_BIT];
   assign ref_go = can_go & ~in_sr & ctrl[sdcmd_pkg::CTRL_REFEN_BIT] &
                   (ref_cnt >= BW'(sdcmd_pkg::REF_AVG_CYC));
   // only the exit order while self refreshing
   assign usr_go = can_go & pend & ~ref_go &
                   (in_sr == (op == sdcmd_pkg::CMD_SREX));
   assign next_sr = usr_go ? ((op == sdcmd_pkg::CMD_SREF) |
                    (in_sr & (op != sdcmd_pkg::CMD_SREX))) : in_sr;
   // mode wait, precharge wait, exit wait
   assign next_busy =
      ref_go ? BW'(REF_WAIT) :
      !usr_go ? (busy_cnt != '0 ? busy_cnt - BW'(1) : '0) :
      (op == sdcmd_pkg::CMD_MRS)  ? BW'(MODE_WAIT) :
      (op == sdcmd_pkg::CMD_SREX) ? BW'(EXIT_WAIT) :
      (op == sdcmd_pkg::CMD_AREF) ? BW'(REF_WAIT) :
      (((op == sdcmd_pkg::CMD_RD) | (op == sdcmd_pkg::CMD_WR)) &
       op_addr[sdcmd_pkg::AP_BIT]) ? BW'(AP_WAIT) : '0;
   assign wr_cmd = wr_i & (addr_i == sdcmd_pkg::REG_CMD) & ~pend;
   assign rd_mux =
      (addr_i == sdcmd_pkg::REG_CMD)   ? {12'h000, op_addr, 1'b0, op_ba, op} :
      (addr_i == sdcmd_pkg::REG_WDATA) ? wdata :
      (addr_i == sdcmd_pkg::REG_STAT)  ? {ref_cnt, busy_cnt} |
                                         {29'h0, in_sr, pend, can_go} :
      (addr_i == sdcmd_pkg::REG_CTRL)  ? {24'h000000, ctrl} : 32'h00000000;

   always_ff @(posedge clk_sys_i)
   begin
      if (!reset_n_i)
      begin
         op      <= sdcmd_pkg::CMD_NOP;
         op_ba   <= '0;
         op_addr <= '0;
         pend    <= 1'b0;
         ctrl    <= sdcmd_pkg::CTRL_RESET;
         wdata   <= '0;
         rdata_o <= '0;
      end
      else
      begin
         rdata_o <= rd_i ? rd_mux : 32'h00000000;
         if (wr_cmd)
         begin
            op      <= sdcmd_pkg::sdcmd_cmd_t'(wdata_i[3:0]);
            op_ba   <= wdata_i[sdcmd_pkg::CMD_BA_LSB +: sdcmd_pkg::BANK_W];
            op_addr <= wdata_i[sdcmd_pkg::CMD_ADDR_LSB +: sdcmd_pkg::ADDR_W];
         end
         pend <= wr_cmd | (pend & ~usr_go);
         if (wr_i && addr_i == sdcmd_pkg::REG_CTRL)
            ctrl <= wdata_i[7:0];
         if (wr_i && addr_i == sdcmd_pkg::REG_WDATA)
            wdata <= wdata_i;
      end
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (!reset_n_i)
      begin
         busy_cnt <= '0;
         ref_cnt  <= '0;
         in_sr    <= 1'b0;
      end
      else
      begin
         busy_cnt <= next_busy;
         in_sr    <= next_sr;
         ref_cnt  <= (ref_go | in_sr) ? '0 : ref_cnt + BW'(1);
      end
   end

   // pins are driven only from flops
   always_ff @(posedge clk_sys_i)
   begin
      if (!reset_n_i)
      begin
         pins.rst_pin_n       <= 1'b0;
         pins.cke             <= 1'b0;
         pins.cs_n            <= 1'b1;
         {pins.ras_n, pins.cas_n, pins.we_n} <= sdcmd_pkg::PIN_NOP;
         pins.ba              <= '0;
         pins.addr            <= '0;
         pins.dq              <= '0;
         pins.write_byte_mask <= '0;
      end
      else
      begin
         pins.rst_pin_n <= ctrl[sdcmd_pkg::CTRL_RST_BIT];
         // strap level while reset pin low, cke low in sr
         pins.cke <= ctrl[sdcmd_pkg::CTRL_RST_BIT] ? ~next_sr
                                          : ctrl[sdcmd_pkg::CTRL_STRAP_BIT];
         pins.cs_n <= ~(ref_go | (usr_go & (op != sdcmd_pkg::CMD_SREX)));
         {pins.ras_n, pins.cas_n, pins.we_n} <=
            ref_go ? sdcmd_pkg::PIN_REF :
            usr_go ? sdcmd_pkg::sdcmd_pins(op) : sdcmd_pkg::PIN_NOP;
         pins.ba   <= op_ba;
         pins.addr <= op_addr;
         pins.dq   <= wdata;
         pins.write_byte_mask <=
            ctrl[sdcmd_pkg::CTRL_MASK_LSB +: sdcmd_pkg::MASK_W];
      end
   end
endmodule
`default_nettype wire

// [verification/sdcmd_asserts.sv]
`timescale 1ns/100ps
`default_nettype none
module sdcmd_asserts (
   input  wire logic        clk_sys_i, // clock
   input  wire logic        reset_n_i, // reset
   input  wire logic        rst_pin_n, // device reset pin
   input  wire logic        cke,       // clock enable
   input  wire logic        cs_n,      // chip select
   input  wire logic        ras_n,     // row strobe
   input  wire logic        cas_n,     // column strobe
   input  wire logic        we_n,      // write enable
   input  wire logic [2:0]  ba,        // bank
   input  wire logic [11:0] addr       // address
);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!reset_n_i);
   wire [2:0]   pin = {ras_n, cas_n, we_n};
   wire         cmd = !cs_n && pin != sdcmd_pkg::PIN_NOP;
   wire         acc = pin == sdcmd_pkg::PIN_RD || pin == sdcmd_pkg::PIN_WR;
   wire         ref_c = cmd && pin == sdcmd_pkg::PIN_REF;
   wire         pre_c = cmd && pin == sdcmd_pkg::PIN_PRE;
   wire         act_c = cmd && pin == sdcmd_pkg::PIN_ACT;
   logic [7:0]  open_q;
   logic [10:0] gap;
   logic        ref_on;
   // spacing of refreshes, counted once the first one was seen
   always_ff @(posedge clk_sys_i)
   begin
      ref_on <= reset_n_i && (ref_on || ref_c);
      gap    <= (ref_c || !cke || !ref_on) ? 11'h000 : gap + 11'h001;
   end
   // banks with an open row as the pins announce them
   always_ff @(posedge clk_sys_i)
   begin
      if (!reset_n_i || (pre_c && addr[8]))
         open_q <= 8'h00;
      else if (act_c)
         open_q[ba] <= 1'b1;
      else if (pre_c || (cmd && acc && addr[8]))
         open_q[ba] <= 1'b0;
   end
   property p_one_cycle; cmd |=> !cmd; endproperty
   a_one_cycle: assert property (p_one_cycle)
      else $error("command held past one cycle");
   property p_mode_wait; cmd && pin == 3'h0 |=> !cmd [*3]; endproperty
   a_mode_wait: assert property (p_mode_wait)
      else $error("command too soon after mode load");
   property p_ap_wait; cmd && acc && addr[8] |=> !cmd [*8]; endproperty
   a_ap_wait: assert property (p_ap_wait)
      else $error("command too soon after auto precharge");
   property p_cke_high; !cs_n && !cke |-> pin inside {3'h1, 3'h7}; endproperty
   a_cke_high: assert property (p_cke_high)
      else $error("command with clock enable low");
   property p_exit; $rose(cke) && rst_pin_n |-> !cmd [*8]; endproperty
   a_exit: assert property (p_exit)
      else $error("command during self refresh exit");
   property p_pin_rst; !rst_pin_n |-> cs_n; endproperty
   a_pin_rst: assert property (p_pin_rst)
      else $error("command while device reset low");
   property p_act_closed; act_c |-> !open_q[ba]; endproperty
   a_act_closed: assert property (p_act_closed)
      else $error("activate to a bank with open row");
   property p_ref_gap; gap < 11'd1755; endproperty
   a_ref_gap: assert property (p_ref_gap)
      else $error("refresh gap too long");
endmodule
`default_nettype wire

// [verification/sdcmd_bench.sv]
`timescale 1ns/100ps
`default_nettype none
module sdcmd_bench;
   logic                  clk_sys_i = 1'b0;
   logic                  reset_n_i = 1'b0;
   logic [3:0]            addr_i = 4'h0;
   logic [31:0]           wdata_i = 32'h0;
   logic                  wr_i = 1'b0;
   logic                  rd_i = 1'b0;
   logic [31:0]           rdata_o, wr_data_o, last_data, d;
   logic [11:0]           cmd_addr_o, refresh_row_o, mode_reg_o;
   logic [11:0]           ext_mode_reg_o, last_addr, row0;
   logic [7:0]            bank_open_o, bank_pre_o;
   logic [3:0]            wr_byte_en_o, last_en;
   logic [2:0]            cmd_bank_o, last_bank;
   logic [1:0]            term_data_sel_o;
   logic                  auto_pre_o, self_refresh_o, dll_en_o, dll_reset_o;
   logic                  term_ca_o, term_ca_half_o, dual_rank_o;
   logic                  term_data_o, wr_valid_o, last_ap;
   sdcmd_pkg::sdcmd_cmd_t cmd_o, last_cmd;
   int                    err_total, check_count, ncmd, lows;
   sdcmd_if u_sdcmd_if ();
   sdcmd_dev u_sdcmd_dev (.clk_sys_i, .reset_n_i, .pins(u_sdcmd_if), .cmd_o,
      .cmd_bank_o, .cmd_addr_o, .auto_pre_o, .bank_open_o, .bank_pre_o,
      .refresh_row_o, .self_refresh_o, .dll_en_o, .dll_reset_o, .term_ca_o,
      .term_ca_half_o, .dual_rank_o, .term_data_o, .term_data_sel_o,
      .mode_reg_o, .ext_mode_reg_o, .wr_valid_o, .wr_data_o, .wr_byte_en_o);
   sdcmd_ctrl #(.EXIT_WAIT(20)) u_sdcmd_ctrl (.clk_sys_i, .reset_n_i,
      .pins(u_sdcmd_if), .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o);
   sdcmd_asserts u_sdcmd_asserts (.clk_sys_i, .reset_n_i,
      .rst_pin_n(u_sdcmd_if.rst_pin_n), .cke(u_sdcmd_if.cke),
      .cs_n(u_sdcmd_if.cs_n), .ras_n(u_sdcmd_if.ras_n),
      .cas_n(u_sdcmd_if.cas_n), .we_n(u_sdcmd_if.we_n),
      .ba(u_sdcmd_if.ba), .addr(u_sdcmd_if.addr));
   initial
   begin
      forever #10 clk_sys_i = ~clk_sys_i;
   end
   // latch short-lived device outputs
   always @(posedge clk_sys_i)
   begin
      if (cmd_o !== sdcmd_pkg::CMD_DESEL && cmd_o !== sdcmd_pkg::CMD_NOP)
      begin
         last_cmd = cmd_o;
         last_bank = cmd_bank_o;
         last_addr = cmd_addr_o;
         last_ap = auto_pre_o;
         ncmd++;
      end
      if (wr_valid_o === 1'b1)
      begin
         last_data = wr_data_o;
         last_en = wr_byte_en_o;
      end
      if (term_data_o === 1'b0 && self_refresh_o === 1'b0)
         lows++;
   end
   task automatic chk(input string n, input logic [31:0] e,
                      input logic [31:0] g);
      check_count++;
      if (g !== e)
      begin
         err_total++;
         $display("FAIL %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge clk_sys_i);
      #1;
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] v);
      @(posedge clk_sys_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= v;
      @(posedge clk_sys_i);
      wr_i <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [31:0] v);
      @(posedge clk_sys_i);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge clk_sys_i);
      rd_i <= 1'b0;
      #1;
      v = rdata_o;
   endtask
   task automatic issue(input sdcmd_pkg::sdcmd_cmd_t op, input logic [2:0] b,
                        input logic [11:0] a);
      int n;
      n = ncmd;
      wr(sdcmd_pkg::REG_CMD, {12'h000, a, 1'b0, b, 4'(op)});
      for (int i = 0; i < 60 && ncmd == n; i++) tick(1);
      tick(1);
   endtask
   task automatic stop_test();
      $display("checks %0d errors %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial
   begin
      #200000;
      err_total++;
      stop_test();
   end
   initial
   begin
      repeat (5) @(posedge clk_sys_i);
      reset_n_i <= 1'b1;
      wr(sdcmd_pkg::REG_CTRL, 32'h2);
      wr(sdcmd_pkg::REG_CTRL, 32'h3);
      tick(2);
      chk("rank", 1, dual_rank_o);
      chk("ca_half", 0, term_ca_half_o);
      chk("ca_term", 1, term_ca_o);
      issue(sdcmd_pkg::CMD_MRS, 3'h1, 12'h004);
      issue(sdcmd_pkg::CMD_MRS, 3'h2, 12'h0FF);
      issue(sdcmd_pkg::CMD_MRS, 3'h0, 12'h031);
      chk("ext_mode", 12'h004, ext_mode_reg_o);
      chk("mode", 12'h031, mode_reg_o);
      chk("odt_sel", 2'h1, term_data_sel_o);
      issue(sdcmd_pkg::CMD_ACT, 3'h2, 12'h123);
      chk("act_bank", 3'h2, last_bank);
      chk("act_row", 12'h123, last_addr);
      chk("open", 8'h04, bank_open_o);
      lows = 0;
      issue(sdcmd_pkg::CMD_RD, 3'h2, 12'h105);
      chk("rd_cmd", sdcmd_pkg::CMD_RD, last_cmd);
      chk("rd_ap", 1, last_ap);
      tick(40);
      chk("odt_off", 4, lows);
      chk("ap_close", 8'h00, bank_open_o | bank_pre_o);
      issue(sdcmd_pkg::CMD_MRS, 3'h1, 12'h000);
      issue(sdcmd_pkg::CMD_ACT, 3'h2, 12'h040);
      lows = 0;
      issue(sdcmd_pkg::CMD_RD, 3'h2, 12'h005);
      tick(30);
      chk("odt_single", 0, lows);
      wr(sdcmd_pkg::REG_WDATA, 32'hA5C31E77);
      wr(sdcmd_pkg::REG_CTRL, 32'h53);
      issue(sdcmd_pkg::CMD_ACT, 3'h1, 12'h010);
      issue(sdcmd_pkg::CMD_WR, 3'h1, 12'h002);
      tick(10);
      chk("byte_en", 4'hA, last_en);
      chk("wdata", 32'hA5C31E77, last_data);
      issue(sdcmd_pkg::CMD_ACT, 3'h3, 12'h020);
      issue(sdcmd_pkg::CMD_PRE, 3'h0, 12'h100);
      chk("pre_all", 8'h0E, bank_pre_o);
      tick(12);
      chk("closed", 8'h00, bank_open_o | bank_pre_o);
      issue(sdcmd_pkg::CMD_PRE, 3'h5, 12'h000);
      chk("pre_idle", 8'h00, bank_pre_o | bank_open_o);
      row0 = refresh_row_o;
      wr(sdcmd_pkg::REG_CTRL, 32'h57);
      for (int i = 0; i < 400 && last_cmd !== sdcmd_pkg::CMD_AREF; i++)
         tick(1);
      tick(3);
      chk("ref_row", row0 + 12'h001, refresh_row_o);
      issue(sdcmd_pkg::CMD_SREF, 3'h0, 12'h000);
      chk("in_sr", 1, self_refresh_o);
      chk("dll_off", 0, dll_en_o);
      chk("odt_sr", 0, term_data_o);
      rd(4'h2, d);
      chk("unmapped", 32'h0, d);
      wr(sdcmd_pkg::REG_CMD, 32'(sdcmd_pkg::CMD_SREX));
      for (int i = 0; i < 40 && dll_reset_o !== 1'b1; i++) tick(1);
      chk("dll_rst", 1, dll_reset_o);
      tick(1);
      chk("sr_exit", 0, self_refresh_o);
      chk("dll_on", 1, dll_en_o);
      stop_test();
   end
endmodule
`default_nettype wire
